// *** node_cfg.v ***
// node configuration register bank with axi4-lite slave, indirect port, command chaining and line gating
`timescale 1ns/1ns
`default_nettype none
`include "node_cfg_regs.vh"
module node_cfg #(
   parameter RESP_BASE = `RESP_TIMEOUT_BASE      // response timeout base, cycles; shorten in simulation
) (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   // axi4-lite slave
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // host interface mode strap, caught after reset release
   input wire host_mode_pin,
   // protocol core, same clock
   input wire next_id_load,
   input wire [7:0] next_id_in,
   input wire [6:0] diag_event,
   input wire cmd_taken,
   output reg [7:0] cmd_out,
   output reg cmd_valid,
   input wire tx_req,             // core wants to drive the line
   input wire tx_bit,             // line level the core wants
   input wire resp_start,         // core starts waiting for a response
   output reg resp_timeout,       // one-cycle pulse when the wait runs out
   output reg soft_reset_active,
   // network medium
   input wire line_in,
   output reg line_out,
   output reg line_oe
);
   ////////////////////////////////////////////////////////////////////////////////
   // state
   reg [7:0] node_configuration;  // host-visible configuration
   reg [7:0] tentative_id;
   reg [7:0] node_id;
   reg [7:0] setup1;
   reg [7:0] next_id;             // written by the core only
   reg [7:0] diag_status;         // sticky diagnostic bits
   reg host_mode;                 // caught strap
   reg strap_taken;               // strap is caught once per hard reset
   reg [1:0] strap_sync;          // two-stage synchroniser for the strap
   reg [1:0] strap_fill;          // synchroniser stages filled since hard reset
   reg [1:0] line_sync;           // two-stage synchroniser for the line
   reg [15:0] resp_count;         // response wait counter
   reg resp_busy;
   reg cmd_wr;                    // one-cycle strobe into the command holder
   reg [7:0] cmd_wdata;

   wire soft_rst;
   wire [1:0] sel;
   wire [1:0] long_code;
   wire [3:0] wr_idx;
   wire [3:0] rd_idx;
   wire wr_fire;
   wire rd_fire;
   wire wr_byte0;
   wire wr_mapped;
   wire rd_mapped;
   wire wr_hit;                   // a mapped low-byte write lands this cycle
   wire chain_lost;
   wire [7:0] chain_cmd;
   wire chain_valid;
   wire [15:0] resp_limit;
   reg [7:0] indirect_rdata;
   reg [7:0] next_rdata;

   assign soft_rst = node_configuration[`BIT_SOFT_RESET];
   assign sel = {node_configuration[`BIT_INDIRECT_SELECT_HI], node_configuration[`BIT_INDIRECT_SELECT_LO]};
   assign long_code = {node_configuration[`BIT_LONG_TIMEOUT_HI], node_configuration[`BIT_LONG_TIMEOUT_LO]};
   assign wr_idx = s_axi_awaddr[`ADDR_LSB+3:`ADDR_LSB];
   assign rd_idx = s_axi_araddr[`ADDR_LSB+3:`ADDR_LSB];
   // address and data are taken together, so the write lands on the handshake edge
   assign wr_fire = s_axi_awready & s_axi_awvalid & s_axi_wready & s_axi_wvalid;
   assign rd_fire = s_axi_arready & s_axi_arvalid;
   assign wr_byte0 = s_axi_wstrb[0];
   assign wr_mapped = (s_axi_awaddr[31:`ADDR_LSB+4] == 26'h0) && (wr_idx <= `OFS_NODE_STATUS);
   assign rd_mapped = (s_axi_araddr[31:`ADDR_LSB+4] == 26'h0) && (rd_idx <= `OFS_NODE_STATUS);
   // unmapped writes answer with an error and must leave every register alone
   assign wr_hit = wr_fire & wr_byte0 & wr_mapped;
   // each long timeout step doubles the wait; codes beyond the top step are not possible
   assign resp_limit = RESP_BASE[15:0] << long_code;

   ////////////////////////////////////////////////////////////////////////////////
   // axi write channel: accept address and data in the same cycle, then answer
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (ce) begin
         // ready is a one-cycle pulse, raised only when both halves wait and no answer is open
         s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
         s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // configuration and directly written registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         node_configuration <= `RST_NODE_CONFIGURATION;   // transmit allow starts cleared
         tentative_id <= `RST_TENTATIVE_ID;
         node_id <= `RST_NODE_ID;
         setup1 <= `RST_SETUP1;
         cmd_wr <= 1'b0;
         cmd_wdata <= 8'h00;
      end else if (ce) begin
         cmd_wr <= 1'b0;
         if (wr_hit) begin
            case (wr_idx)
               // soft reset never touches this register, so the host alone releases it
               `OFS_NODE_CONFIGURATION: node_configuration <= s_axi_wdata[7:0];
               `OFS_INDIRECT_PORT: begin
                  // the write goes where the current select code points
                  case (sel)
                     `SEL_TENTATIVE_ID: tentative_id <= s_axi_wdata[7:0];
                     `SEL_NODE_ID: node_id <= s_axi_wdata[7:0];
                     `SEL_SETUP1: setup1 <= s_axi_wdata[7:0];
                     default: ;   // next id is read-only to the host
                  endcase
               end
               `OFS_COMMAND: begin
                  // commands are ignored while soft reset holds the node
                  cmd_wr <= ~soft_rst;
                  cmd_wdata <= s_axi_wdata[7:0];
               end
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers that soft reset clears
   always @(posedge aclk) begin
      if (!aresetn) begin
         next_id <= `RST_NEXT_ID;
         diag_status <= `RST_DIAG_STATUS;
      end else if (ce) begin
         if (soft_rst) begin
            // this set and the command holder are cleared; tentative id, node id and setup survive
            next_id <= `RST_NEXT_ID;
            diag_status <= `RST_DIAG_STATUS;
         end else begin
            if (next_id_load) begin
               next_id <= next_id_in;
            end
            // write-one-to-clear; a new event in the same cycle wins over the clear
            diag_status <= (diag_status & ~((wr_hit && wr_idx == `OFS_DIAG_STATUS) ?
                            s_axi_wdata[7:0] : 8'h00)) | {chain_lost, diag_event};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // host mode strap and line synchronisers
   always @(posedge aclk) begin
      if (!aresetn) begin
         strap_sync <= 2'b00;
         line_sync <= 2'b00;
         host_mode <= 1'b0;
         strap_taken <= 1'b0;
         strap_fill <= 2'b00;
      end else if (ce) begin
         strap_sync <= {strap_sync[0], host_mode_pin};
         line_sync <= {line_sync[0], line_in};
         if (!strap_fill[1]) begin
            strap_fill <= strap_fill + 2'b01;
         end
         // caught once after hard reset; soft reset leaves it alone
         // the extra wait lets the synchroniser fill before the strap is trusted
         if (!strap_taken && strap_fill[1]) begin
            strap_taken <= 1'b1;
            host_mode <= strap_sync[1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // command holder, queueing or single as chaining says
   cmd_chain u_chain (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .flush(soft_rst),
      .chain_on(node_configuration[`BIT_CMD_CHAIN_ON]),
      .cmd_wr(cmd_wr),
      .cmd_in(cmd_wdata),
      .cmd_taken(cmd_taken),
      .cmd_out(chain_cmd),
      .cmd_valid(chain_valid),
      .cmd_lost(chain_lost)
   );

   // core-facing copies kept in flip-flops one cycle behind the holder
   always @(posedge aclk) begin
      if (!aresetn) begin
         cmd_out <= 8'h00;
         cmd_valid <= 1'b0;
         soft_reset_active <= 1'b0;
      end else if (ce) begin
         cmd_out <= chain_cmd;
         cmd_valid <= chain_valid & ~cmd_taken;
         soft_reset_active <= soft_rst;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // response timeout, length set by the long timeout bits
   always @(posedge aclk) begin
      if (!aresetn) begin
         resp_count <= 16'h0000;
         resp_busy <= 1'b0;
         resp_timeout <= 1'b0;
      end else if (ce) begin
         resp_timeout <= 1'b0;
         if (soft_rst) begin
            resp_busy <= 1'b0;
            resp_count <= 16'h0000;
         end else if (resp_start) begin
            resp_busy <= 1'b1;
            resp_count <= 16'h0000;
         end else if (resp_busy) begin
            if (resp_count == resp_limit - 16'h0001) begin
               resp_busy <= 1'b0;
               resp_timeout <= 1'b1;
            end else begin
               resp_count <= resp_count + 16'h0001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // line driver: gated by transmit allow, shaped by backplane mode
   always @(posedge aclk) begin
      if (!aresetn) begin
         line_out <= 1'b0;
         line_oe <= 1'b0;
      end else if (ce) begin
         if (!node_configuration[`BIT_TRANSMIT_ALLOW] || soft_rst || !tx_req) begin
            // nothing reaches the medium while transmit is not allowed
            line_out <= 1'b0;
            line_oe <= 1'b0;
         end else if (node_configuration[`BIT_BACKPLANE]) begin
            // open-drain: only a low is driven, a high is left to the pull-up
            line_out <= 1'b0;
            line_oe <= ~tx_bit;
         end else begin
            line_out <= tx_bit;
            line_oe <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read side
   always @* begin
      next_rdata = next_id;
      // indirect reads follow the current select code
      case (sel)
         `SEL_TENTATIVE_ID: indirect_rdata = tentative_id;
         `SEL_NODE_ID: indirect_rdata = node_id;
         `SEL_SETUP1: indirect_rdata = setup1;
         `SEL_NEXT_ID: indirect_rdata = next_rdata;
         default: indirect_rdata = 8'h00;
      endcase
   end

   // read answer one cycle after the address is taken, held until rready
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
            // an unmapped place falls to the default branch and reads zero
            case (rd_mapped ? rd_idx : 4'hf)
               `OFS_NODE_CONFIGURATION: s_axi_rdata <= {24'h000000, node_configuration};
               `OFS_INDIRECT_PORT: s_axi_rdata <= {24'h000000, indirect_rdata};
               `OFS_DIAG_STATUS: s_axi_rdata <= {24'h000000, diag_status};
               `OFS_COMMAND: s_axi_rdata <= {24'h000000, chain_cmd};
               `OFS_NODE_STATUS: s_axi_rdata <= {26'h0000000, host_mode, line_sync[1], line_oe,
                                                 chain_valid, resp_busy, soft_rst};
               default: s_axi_rdata <= 32'h00000000;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** node_cfg_regs.vh ***
// register offsets, field positions, reset values and timing counts of the node configuration block
`ifndef NODE_CFG_REGS_VH
`define NODE_CFG_REGS_VH

// register indices; the byte address on the bus is four times the index
`define OFS_NODE_CONFIGURATION 4'h0
`define OFS_INDIRECT_PORT 4'h1
`define OFS_DIAG_STATUS 4'h2
`define OFS_COMMAND 4'h3
`define OFS_NODE_STATUS 4'h4
`define ADDR_LSB 2

// node_configuration field positions
`define BIT_INDIRECT_SELECT_LO 0
`define BIT_INDIRECT_SELECT_HI 1
`define BIT_BACKPLANE 2
`define BIT_LONG_TIMEOUT_HI 3
`define BIT_LONG_TIMEOUT_LO 4
`define BIT_TRANSMIT_ALLOW 5
`define BIT_CMD_CHAIN_ON 6
`define BIT_SOFT_RESET 7

// indirect select codes
`define SEL_TENTATIVE_ID 2'h0
`define SEL_NODE_ID 2'h1
`define SEL_SETUP1 2'h2
`define SEL_NEXT_ID 2'h3

// reset values
`define RST_NODE_CONFIGURATION 8'h00
`define RST_TENTATIVE_ID 8'h00
`define RST_NODE_ID 8'h00
`define RST_SETUP1 8'h00
`define RST_NEXT_ID 8'h00
`define RST_DIAG_STATUS 8'h00

// diagnostic status bit fed by the command queue
`define BIT_DIAG_CMD_LOST 7

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// response timeout, base figure in cycles of aclk
`define RESP_TIMEOUT_BASE 1000
`endif

// *** cmd_chain.v ***
// two-slot command holder: queues commands when chaining is on, single register otherwise
`timescale 1ns/1ns
`default_nettype none
module cmd_chain (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   input wire flush,              // soft reset empties both slots
   input wire chain_on,           // queue successive commands
   input wire cmd_wr,             // one-cycle strobe from the register bus
   input wire [7:0] cmd_in,
   input wire cmd_taken,          // core consumed the active command
   output reg [7:0] cmd_out,      // active command
   output reg cmd_valid,
   output reg cmd_lost            // one-cycle pulse: queue was full
);
   reg [7:0] queued;              // second slot, only used while chaining
   reg queued_valid;
   wire pop;
   wire slot0_free;

   assign pop = cmd_taken & cmd_valid;
   assign slot0_free = ~cmd_valid | pop;

   // slot update; a pop and a push in one cycle both take effect
   always @(posedge aclk) begin
      if (!aresetn || (ce && flush)) begin
         cmd_out <= 8'h00;
         cmd_valid <= 1'b0;
         queued <= 8'h00;
         queued_valid <= 1'b0;
         cmd_lost <= 1'b0;
      end else if (ce) begin
         cmd_lost <= 1'b0;
         if (pop) begin
            cmd_valid <= queued_valid;
            cmd_out <= queued;
            queued_valid <= 1'b0;
         end
         if (cmd_wr) begin
            if (!chain_on) begin
               // legacy behaviour: the one command register is simply overwritten
               cmd_out <= cmd_in;
               cmd_valid <= 1'b1;
               queued_valid <= 1'b0;
            end else if (slot0_free && !(pop && queued_valid)) begin
               cmd_out <= cmd_in;
               cmd_valid <= 1'b1;
            end else if (!queued_valid || pop) begin
               queued <= cmd_in;
               queued_valid <= 1'b1;
            end else begin
               cmd_lost <= 1'b1;        // both slots busy, command dropped
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** node_cfg_chk.sv ***
// concurrent checks on the ports of the node configuration bank
`timescale 1ns/1ns
`default_nettype none
module node_cfg_chk #(
   parameter RESP_BASE = 1000 // response timeout base, cycles
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cmd_valid,
   input wire logic tx_req,
   input wire logic tx_bit,
   input wire logic resp_start,
   input wire logic resp_timeout,
   input wire logic soft_reset_active,
   input wire logic line_out,
   input wire logic line_oe
);
   // one domain: all checks share clock and reset
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   //////////////////////////////////////////////////////////////////////////////
   // line driver: gated by request, soft reset and level rules
   AST_TX_REQ_GATE: assert property (ce && !tx_req |=> !line_oe)
      else $error("line driven without a request");
   AST_OE_NEEDS_REQ: assert property ($past(ce) && line_oe |-> $past(tx_req))
      else $error("line enable without prior request");
   AST_SOFT_RESET_QUIET: assert property (soft_reset_active |-> !line_oe)
      else $error("line driven during soft reset");
   AST_OUT_HIGH: assert property ($past(ce) && line_out |-> line_oe && $past(tx_bit))
      else $error("line high level not from tx bit");
   AST_OUT_LOW: assert property ($past(ce) && line_oe && !line_out |-> !$past(tx_bit))
      else $error("line pulled low while tx bit high");
   // soft reset empties the command holder
   AST_FLUSH: assert property (ce && soft_reset_active |=> !cmd_valid)
      else $error("command kept through soft reset");
   // no timeout pulse in the six cycles after a start
   AST_TIMER_MIN: assert property (ce && resp_start |=> !resp_timeout [*6])
      else $error("response timeout too early");
   //////////////////////////////////////////////////////////////////////////////
   // register bus handshakes
   AST_AW_W_TOGETHER: assert property (s_axi_awready |-> s_axi_wready && !s_axi_bvalid)
      else $error("address and data not taken together");
   AST_B_FOLLOWS: assert property (ce && s_axi_awready |=> s_axi_bvalid && !s_axi_awready)
      else $error("write response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_AR_TO_R: assert property (ce && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_RDATA_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
endmodule
bind node_cfg node_cfg_chk #(.RESP_BASE(RESP_BASE)) u_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .cmd_valid(cmd_valid), .tx_req(tx_req), .tx_bit(tx_bit), .resp_start(resp_start),
   .resp_timeout(resp_timeout), .soft_reset_active(soft_reset_active), .line_out(line_out), .line_oe(line_oe));
`default_nettype wire

// *** token_ring_node_config_register_tb_top.sv ***
// self-checking bench for the node configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "node_cfg_regs.vh"
module token_ring_node_config_register_tb_top;
   localparam int BASE = 8; // short timeout base keeps the run brief
   logic aclk = 0, aresetn = 0, ce = 1; // ce starts high; freezing is exercised only at the end of the sequence
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic host_mode_pin = 1, next_id_load = 0, cmd_taken = 0, tx_req = 0, tx_bit = 0, resp_start = 0, line_in = 0;
   logic [7:0] next_id_in = 0, cmd_out;
   logic [6:0] diag_event = 0;
   logic cmd_valid, resp_timeout, soft_reset_active, line_out, line_oe;
   logic [31:0] rd;
   int n_fail = 0, comparisons = 0;
   int lat [4]; // measured timeout per code
   always #10 aclk = ~aclk;
   node_cfg #(.RESP_BASE(BASE)) u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .host_mode_pin(host_mode_pin),
      .next_id_load(next_id_load), .next_id_in(next_id_in), .diag_event(diag_event), .cmd_taken(cmd_taken),
      .cmd_out(cmd_out), .cmd_valid(cmd_valid), .tx_req(tx_req), .tx_bit(tx_bit), .resp_start(resp_start),
      .resp_timeout(resp_timeout), .soft_reset_active(soft_reset_active), .line_in(line_in),
      .line_out(line_out), .line_oe(line_oe));
   //////////////////////////////////////////////////////////////////////////////
   // verdict and compare tasks
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_word({31'h0, got}, {31'h0, exp}, what);
   endtask
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
      chk_word({30'h0, got}, {30'h0, exp}, what);
   endtask
   task automatic ncyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // register bus master: called just after a rising edge
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 0; s_axi_wvalid <= 0; s_axi_bready <= 1;
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a; s_axi_arvalid <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0; s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata; r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   // register index to byte address; each register holds one word
   task automatic wreg(input logic [3:0] ofs, input logic [31:0] d);
      axi_wr({28'h0, ofs} << `ADDR_LSB, d, rs);
      chk_resp(rs, `RESP_OKAY, "write response");
   endtask
   task automatic rreg(input logic [3:0] ofs, input logic [31:0] exp, input string what);
      axi_rd({28'h0, ofs} << `ADDR_LSB, rd, rs);
      chk_resp(rs, `RESP_OKAY, "read response");
      chk_word(rd, exp, what);
   endtask
   task automatic take;
      cmd_taken <= 1; @(posedge aclk); cmd_taken <= 0; ncyc(2);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rreg(`OFS_NODE_CONFIGURATION, 32'h0, "config reset");
      chk_bit(line_oe, 1'b0, "oe after reset");
      next_id_in <= 8'h5a; next_id_load <= 1; @(posedge aclk); next_id_load <= 0;
      // each select code reaches its own register; next id is read-only
      for (int k = 0; k < 3; k++) begin
         wreg(`OFS_NODE_CONFIGURATION, k);
         wreg(`OFS_INDIRECT_PORT, 32'h40 + k);
      end
      for (int k = 3; k >= 0; k--) begin
         wreg(`OFS_NODE_CONFIGURATION, k);
         if (k == 3) wreg(`OFS_INDIRECT_PORT, 32'hff);
         rreg(`OFS_INDIRECT_PORT, (k == 3) ? 32'h5a : 32'h40 + k, "indirect");
      end
      // diagnostics: event sets, write-one clears, soft reset wipes
      diag_event <= 7'h05; @(posedge aclk); diag_event <= 7'h00;
      rreg(`OFS_DIAG_STATUS, 32'h05, "diag set");
      wreg(`OFS_DIAG_STATUS, 32'h01);
      rreg(`OFS_DIAG_STATUS, 32'h04, "diag w1c");
      wreg(`OFS_NODE_CONFIGURATION, 32'h85); ncyc(2);
      chk_bit(soft_reset_active, 1'b1, "soft reset on");
      rreg(`OFS_NODE_CONFIGURATION, 32'h85, "config kept");
      rreg(`OFS_NODE_STATUS, 32'h21, "status in soft reset");
      rreg(`OFS_INDIRECT_PORT, 32'h41, "node id kept");
      rreg(`OFS_DIAG_STATUS, 32'h0, "diag wiped");
      wreg(`OFS_NODE_CONFIGURATION, 32'h87);
      rreg(`OFS_INDIRECT_PORT, 32'h0, "next id wiped");
      wreg(`OFS_NODE_CONFIGURATION, 32'h00); ncyc(2); // host leaves reset
      chk_bit(soft_reset_active, 1'b0, "soft reset off");
      // chaining off: last write wins
      wreg(`OFS_COMMAND, 32'h11); wreg(`OFS_COMMAND, 32'h22); ncyc(2);
      chk_word({24'h0, cmd_out}, 32'h22, "single command");
      take();
      chk_bit(cmd_valid, 1'b0, "single consumed");
      // chaining on: two slots, a third write is lost and flagged
      wreg(`OFS_NODE_CONFIGURATION, 32'h40);
      for (int k = 0; k < 3; k++) wreg(`OFS_COMMAND, 32'h33 + 32'h11 * k);
      ncyc(2);
      chk_word({24'h0, cmd_out}, 32'h33, "first queued");
      rreg(`OFS_DIAG_STATUS, 32'h80, "command lost");
      take();
      chk_word({24'h0, cmd_out}, 32'h44, "second queued");
      take();
      chk_bit(cmd_valid, 1'b0, "queue empty");
      // line: blocked until allowed, then push-pull or backplane
      tx_req <= 1; tx_bit <= 1; ncyc(3);
      chk_bit(line_oe, 1'b0, "tx blocked");
      wreg(`OFS_NODE_CONFIGURATION, 32'h20); ncyc(2);
      chk_word({line_oe, line_out}, 2'b11, "push-pull high");
      wreg(`OFS_NODE_CONFIGURATION, 32'h24); ncyc(2);
      chk_word({line_oe, line_out}, 2'b00, "backplane released");
      tx_bit <= 0; ncyc(2);
      chk_word({line_oe, line_out}, 2'b10, "backplane pulls low");
      tx_req <= 0;
      // timeout grows by doubling per code; code is {bit3,bit4}
      for (int c = 0; c < 4; c++) begin
         wreg(`OFS_NODE_CONFIGURATION, (c[1] ? 32'h08 : 32'h0) | (c[0] ? 32'h10 : 32'h0));
         resp_start <= 1; @(posedge aclk); resp_start <= 0;
         lat[c] = 0;
         while (!resp_timeout) begin
            @(posedge aclk); lat[c]++;
         end
         chk_word(32'(lat[c] - lat[0]), 32'(BASE * ((1 << c) - 1)), "timeout step");
      end
      chk_bit(lat[0] >= BASE - 1 && lat[0] <= BASE + 2, 1'b1, "base timeout");
      // unmapped place: error, no data
      @(posedge aclk);
      axi_rd(32'h40, rd, rs);
      chk_resp(rs, `RESP_SLVERR, "unmapped read");
      chk_word(rd, 32'h0, "unmapped data");
      axi_wr(32'h40, 32'hff, rs);
      chk_resp(rs, `RESP_SLVERR, "unmapped write");
      rreg(`OFS_NODE_CONFIGURATION, 32'h18, "unmapped write no effect");
      // clock enable low: an event during the freeze is not recorded
      ce <= 0; diag_event <= 7'h02; ncyc(2);
      ce <= 1; diag_event <= 7'h00; @(posedge aclk);
      rreg(`OFS_DIAG_STATUS, 32'h80, "frozen by ce");
      tally_and_finish();
   end
   // watchdog: the sequence needs well under this
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule
`default_nettype wire
